//--- design/rtx_engine.sv
/*
 auto acknowledge / auto retransmit engine with apb registers.
 assumes packet assembly, crc check and address decode sit outside
 and talk over the air_* ports, each pulse lasting one pclk cycle.
*/
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "rtx_defines.svh"

module rtx_engine
  import rtx_pkg::*;
#(
  parameter int ARD_STEP_CYC = `RTX_ARD_STEP_US * `RTX_CLK_MHZ,
  parameter int AW_CYC       = `RTX_AW_US * `RTX_CLK_MHZ,
  parameter int AW_LOW_CYC   = `RTX_AW_LOW_US * `RTX_CLK_MHZ
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // chip enable pin
  input  wire logic        chip_enable,
  // packet transmit side
  output logic             air_tx_start,
  output logic [31:0]      air_tx_data,
  output logic [1:0]       air_tx_pid,
  output logic             air_tx_no_ack,
  output logic             air_tx_is_ack,
  output logic             air_tx_has_pay,
  input  wire logic        air_tx_done,
  // packet receive side
  input  wire logic        air_addr_match,
  input  wire logic        air_rx_valid,
  input  wire logic        air_rx_crc_ok,
  input  wire logic [2:0]  air_rx_pipe,
  input  wire logic [1:0]  air_rx_pid,
  input  wire logic [15:0] air_rx_crc,
  input  wire logic        air_rx_no_ack,
  input  wire logic        air_rx_has_pay,
  input  wire logic [31:0] air_rx_data,
  // receive fifo write
  output logic             rx_fifo_valid,
  output logic [31:0]      rx_fifo_data,
  output logic [2:0]       rx_fifo_pipe
);
  localparam int NS = `RTX_REPLY_SLOTS;

  logic [10:0]       ctrl;
  logic [2:0]        status;
  logic [7:0]        retry_setup_reg;
  logic [6:0]        channel_select_reg;
  logic [3:0]        lost_packet_counter;
  logic [3:0]        transaction_retry_counter;
  logic [31:0]       tx_payload;
  logic              tx_full;
  logic              reuse;
  logic [1:0]        tx_pid;
  logic [31:0]       slot_data [NS];
  logic [2:0]        slot_pipe [NS];
  logic [1:0]        slot_cnt;
  rtx_state_t        state;
  logic              ce_q;
  logic [19:0]       ard_cnt;
  logic [19:0]       aw_cnt;
  logic              addr_seen;
  logic              have_last;
  logic [1:0]        last_pid;
  logic [15:0]       last_crc;
  logic              pay_acked;
  logic [2:0]        ev;
  logic              wr;
  logic              rd;

  wire logic prim_rx  = ctrl[`RTX_B_PRIM_RX];
  wire logic auto_ack = ctrl[`RTX_B_AUTO_ACK];
  wire logic [2:0] reply_pipe = ctrl[`RTX_B_PIPE_LO +: 3];
  wire logic ce_rise = chip_enable & ~ce_q;
  wire logic lim_hit = transaction_retry_counter == retry_setup_reg[3:0];
  wire logic [19:0] ard_cyc =
    20'((32'(retry_setup_reg[7:4]) + 32'd1) * ARD_STEP_CYC);
  wire logic [19:0] aw_lim =
    ctrl[`RTX_B_LOW_RATE] ? 20'(AW_LOW_CYC) : 20'(AW_CYC);
  wire logic ard_done = ard_cnt >= ard_cyc;
  // reuse mode needs a fresh chip enable pulse for every send
  wire logic go_tx = tx_full & (reuse ? ce_rise : chip_enable);
  wire logic rx_ok = air_rx_valid & air_rx_crc_ok;
  wire logic dup = auto_ack & have_last & (air_rx_pid == last_pid)
                   & (air_rx_crc == last_crc);
  wire logic need_ack = auto_ack & ~air_rx_no_ack;
  wire logic lost = (air_rx_valid & ~air_rx_crc_ok) | ard_done
                    | (~addr_seen & aw_cnt >= aw_lim);
  // payload is released at the edge that raises the sent event, so
  // standby never sees a stale full flag and sends the packet twice
  wire logic tx_acked = (state == RTX_WAIT_ACK & rx_ok)
                        | (state == RTX_TX & air_tx_done
                           & ~(auto_ack & ~air_tx_no_ack));

  // oldest waiting reply for a pipe, NS when none
  function automatic logic [1:0] rtx_pick(input logic [2:0] p,
                                          input logic [1:0] n);
    logic [1:0] k;
    k = 2'(NS);
    for (int i = NS - 1; i >= 0; i--) begin
      if (2'(i) < n && slot_pipe[i] == p) begin
        k = 2'(i);
      end
    end
    return k;
  endfunction

  function automatic logic [3:0] rtx_sat_inc(input logic [3:0] v);
    return (v == 4'hf) ? v : v + 4'h1;
  endfunction

  wire logic [1:0] pick = rtx_pick(air_rx_pipe, slot_cnt);
  wire logic take = (state == RTX_RX_SEARCH) & rx_ok & need_ack
                    & (pick != 2'(NS));

  // apb: one wait cycle, then the access completes
  assign wr = psel & penable & pready & pwrite;
  assign rd = psel & penable & ~pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      // error stands with the pready of any access to a bad address; writes fail too
      pslverr <= rd && (paddr > `RTX_A_CMD || paddr[1:0] != 2'h0);
      if (rd) begin
        case (paddr)
          `RTX_A_CTRL:    prdata <= {21'h0, ctrl};
          `RTX_A_STATUS:  prdata <= {21'h0, state, 1'b0, slot_cnt,
                                     tx_full, 1'b0, status};
          `RTX_A_RETRY:   prdata <= {24'h0, retry_setup_reg};
          `RTX_A_CHAN:    prdata <= {25'h0, channel_select_reg};
          `RTX_A_OBSERVE: prdata <= {24'h0, lost_packet_counter,
                                     transaction_retry_counter};
          default:        prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl               <= 11'h0;
      retry_setup_reg    <= `RTX_RST_RETRY;
      channel_select_reg <= `RTX_RST_CHAN;
    end else if (wr) begin
      if (paddr == `RTX_A_CTRL) ctrl <= pwdata[10:0];
      if (paddr == `RTX_A_RETRY) retry_setup_reg <= pwdata[7:0];
      if (paddr == `RTX_A_CHAN) channel_select_reg <= pwdata[6:0];
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 3'h0;
    end else begin
      status <= (status & ~((wr && paddr == `RTX_A_STATUS) ?
                 pwdata[2:0] : 3'h0)) | ev;
    end
  end

  // sender payload: pid steps for every new payload, not for reuse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_payload <= 32'h0;
      tx_full    <= 1'b0;
      reuse      <= 1'b0;
      tx_pid     <= 2'h0;
    end else begin
      if (wr && paddr == `RTX_A_TXDATA && !tx_full) begin
        tx_payload <= pwdata;
        tx_full    <= 1'b1;
        reuse      <= 1'b0;
        tx_pid     <= tx_pid + 2'h1;
      end else if (wr && paddr == `RTX_A_CMD && pwdata[`RTX_B_FLUSH]) begin
        tx_full <= 1'b0;
        reuse   <= 1'b0;
      end else if (wr && paddr == `RTX_A_CMD && pwdata[`RTX_B_REUSE]) begin
        reuse <= 1'b1;
      end else if (!prim_rx && !reuse && tx_acked) begin
        tx_full <= 1'b0;
      end
    end
  end

  // reply slots kept packed oldest first, so first match is fifo order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_cnt <= 2'h0;
    end else if (wr && paddr == `RTX_A_CMD && pwdata[`RTX_B_FLUSH]) begin
      slot_cnt <= 2'h0;
    end else if (take) begin
      slot_cnt <= slot_cnt - 2'h1;
    end else if (wr && paddr == `RTX_A_REPLY && slot_cnt != 2'(NS)
                 && ctrl[`RTX_B_REPLY_EN] && ctrl[`RTX_B_VAR_LEN]) begin
      slot_cnt <= slot_cnt + 2'h1;
    end
  end

  always_ff @(posedge pclk) begin
    if (take) begin
      for (int i = 0; i < NS - 1; i++) begin
        if (2'(i) >= pick) begin
          slot_data[i] <= slot_data[i+1];
          slot_pipe[i] <= slot_pipe[i+1];
        end
      end
    end else if (wr && paddr == `RTX_A_REPLY && slot_cnt != 2'(NS)) begin
      slot_data[slot_cnt] <= pwdata;
      slot_pipe[slot_cnt] <= reply_pipe;
    end
  end

  // loss counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lost_packet_counter       <= 4'h0;
      transaction_retry_counter <= 4'h0;
    end else begin
      if (wr && paddr == `RTX_A_CHAN) begin
        lost_packet_counter <= 4'h0;
      end else if (state == RTX_WAIT_ACK && lost) begin
        lost_packet_counter <= rtx_sat_inc(lost_packet_counter);
      end
      if ((state == RTX_STBY1 || state == RTX_STBY2)
          && !prim_rx && go_tx) begin
        transaction_retry_counter <= 4'h0;
      end else if (state == RTX_WAIT_ACK && lost && !lim_hit) begin
        transaction_retry_counter <= transaction_retry_counter + 4'h1;
      end
    end
  end

  // retry delay from end of packet; ack window until address match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ard_cnt   <= 20'h0;
      aw_cnt    <= 20'h0;
      addr_seen <= 1'b0;
      ce_q      <= 1'b0;
    end else begin
      ce_q <= chip_enable;
      if (state == RTX_TX) begin
        ard_cnt   <= 20'h0;
        aw_cnt    <= 20'h0;
        addr_seen <= 1'b0;
      end else begin
        ard_cnt <= ard_done ? ard_cnt : ard_cnt + 20'h1;
        aw_cnt  <= aw_cnt + 20'h1;
        if (air_addr_match) addr_seen <= 1'b1;
      end
    end
  end

  // main state machine and its one-cycle outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state          <= RTX_STBY1;
      ev             <= 3'h0;
      air_tx_start   <= 1'b0;
      air_tx_data    <= 32'h0;
      air_tx_pid     <= 2'h0;
      air_tx_no_ack  <= 1'b0;
      air_tx_is_ack  <= 1'b0;
      air_tx_has_pay <= 1'b0;
      rx_fifo_valid  <= 1'b0;
      rx_fifo_data   <= 32'h0;
      rx_fifo_pipe   <= 3'h0;
      have_last      <= 1'b0;
      last_pid       <= 2'h0;
      last_crc       <= 16'h0;
      pay_acked      <= 1'b0;
    end else begin
      ev            <= 3'h0;
      air_tx_start  <= 1'b0;
      rx_fifo_valid <= 1'b0;
      case (state)
        RTX_STBY1, RTX_STBY2: begin
          if (prim_rx) begin
            if (chip_enable) state <= RTX_RX_SEARCH;
          end else if (go_tx) begin
            state          <= RTX_TX;
            air_tx_start   <= 1'b1;
            air_tx_data    <= tx_payload;
            air_tx_pid     <= tx_pid;
            air_tx_no_ack  <= ctrl[`RTX_B_NO_ACK];
            air_tx_is_ack  <= 1'b0;
            air_tx_has_pay <= 1'b1;
          end else if (chip_enable) begin
            state <= RTX_STBY2;
          end else begin
            state <= RTX_STBY1;
          end
        end
        RTX_TX: begin
          if (air_tx_done) begin
            if (auto_ack && !air_tx_no_ack) begin
              state <= RTX_WAIT_ACK;
            end else begin
              state <= RTX_STBY1;
              ev[`RTX_B_TX_SENT] <= 1'b1;
            end
          end
        end
        RTX_WAIT_ACK: begin
          if (rx_ok) begin
            state <= RTX_STBY1;
            ev[`RTX_B_TX_SENT] <= 1'b1;
            if (air_rx_has_pay) begin
              ev[`RTX_B_RX_READY] <= 1'b1;
              rx_fifo_valid <= 1'b1;
              rx_fifo_data  <= air_rx_data;
              rx_fifo_pipe  <= air_rx_pipe;
            end
          end else if (lost) begin
            if (lim_hit) begin
              state <= RTX_STBY1;
              ev[`RTX_B_RETRY_LIM] <= 1'b1;
            end else begin
              state <= RTX_RETRY_WAIT;
            end
          end
        end
        RTX_RETRY_WAIT: begin
          if (ard_done) begin
            state        <= RTX_TX;
            air_tx_start <= 1'b1;
          end
        end
        RTX_RX_SEARCH: begin
          if (!chip_enable) begin
            state <= RTX_STBY1;
          end else if (rx_ok) begin
            if (!dup) begin
              have_last     <= 1'b1;
              last_pid      <= air_rx_pid;
              last_crc      <= air_rx_crc;
              rx_fifo_valid <= 1'b1;
              rx_fifo_data  <= air_rx_data;
              rx_fifo_pipe  <= air_rx_pipe;
              ev[`RTX_B_RX_READY] <= 1'b1;
              ev[`RTX_B_TX_SENT]  <= pay_acked;
              pay_acked     <= 1'b0;
            end
            if (need_ack) begin
              state          <= RTX_ACK_TX;
              air_tx_start   <= 1'b1;
              air_tx_is_ack  <= 1'b1;
              air_tx_no_ack  <= 1'b0;
              air_tx_pid     <= air_rx_pid;
              air_tx_has_pay <= take;
              air_tx_data    <= take ? slot_data[pick] : 32'h0;
              if (take) pay_acked <= 1'b1;
            end
          end
        end
        RTX_ACK_TX: begin
          if (air_tx_done) state <= RTX_RX_SEARCH;
        end
        default: state <= RTX_STBY1;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_good_rx;
    state == RTX_RX_SEARCH && chip_enable && rx_ok && !dup;
  endsequence
  sequence s_ack_due;
    state == RTX_RX_SEARCH && chip_enable && rx_ok && need_ack;
  endsequence

  chk_rx_deliver: assert property (s_good_rx |=> rx_fifo_valid
    ##1 status[`RTX_B_RX_READY])
    else $error("new packet not delivered");
  chk_ack_sent: assert property (s_ack_due |=> air_tx_start
    && air_tx_is_ack && state == RTX_ACK_TX)
    else $error("acknowledge missing");
  chk_no_ack_skip: assert property (state == RTX_RX_SEARCH
    && rx_ok && air_rx_no_ack |=> !air_tx_start)
    else $error("acknowledge sent for skip ack packet");
  chk_slot_bound: assert property (slot_cnt == 2'(NS) && !take
    && !(wr && paddr == `RTX_A_CMD) |=> slot_cnt == 2'(NS))
    else $error("reply slot count changed while full");
  chk_retry_bound: assert property (state == RTX_TX && !prim_rx
    |-> transaction_retry_counter <= retry_setup_reg[3:0])
    else $error("retry limit exceeded");
  chk_limit_event: assert property (state == RTX_WAIT_ACK && !rx_ok
    && lost && lim_hit |=> state == RTX_STBY1
    && ev[`RTX_B_RETRY_LIM])
    else $error("retry limit event missing");
  chk_resend_delay: assert property (state == RTX_RETRY_WAIT
    && !ard_done |=> state == RTX_RETRY_WAIT && !air_tx_start)
    else $error("retransmit before retry delay");
  chk_ack_events: assert property (state == RTX_WAIT_ACK && rx_ok
    |=> ev[`RTX_B_TX_SENT] && ev[`RTX_B_RX_READY] == $past(air_rx_has_pay)
    ##1 status[`RTX_B_TX_SENT])
    else $error("ack events wrong");
  chk_chan_clear: assert property (wr && paddr == `RTX_A_CHAN
    |=> lost_packet_counter == 4'h0)
    else $error("channel write did not clear lost counter");
  chk_sby2: assert property (!prim_rx && state == RTX_STBY1
    && chip_enable && !tx_full |=> state == RTX_STBY2)
    else $error("standby-II not entered");
endmodule
`default_nettype wire

//--- common/rtx_defines.svh
/*
 register offsets, field positions, reset values and time figures
 for the packet transaction engine; included by bare name
*/
`ifndef RTX_DEFINES_SVH
`define RTX_DEFINES_SVH
`define RTX_CLK_MHZ       100
`define RTX_ARD_STEP_US   250
`define RTX_AW_US         250
`define RTX_AW_LOW_US     500
`define RTX_REPLY_SLOTS   3
`define RTX_A_CTRL        8'h00
`define RTX_A_STATUS      8'h04
`define RTX_A_RETRY       8'h08
`define RTX_A_CHAN        8'h0c
`define RTX_A_OBSERVE     8'h10
`define RTX_A_TXDATA      8'h14
`define RTX_A_REPLY       8'h18
`define RTX_A_CMD         8'h1c
`define RTX_B_PRIM_RX     0
`define RTX_B_AUTO_ACK    1
`define RTX_B_REPLY_EN    2
`define RTX_B_VAR_LEN     3
`define RTX_B_LOW_RATE    4
`define RTX_B_NO_ACK      5
`define RTX_B_PIPE_LO     8
`define RTX_B_RX_READY    0
`define RTX_B_TX_SENT     1
`define RTX_B_RETRY_LIM   2
`define RTX_B_FLUSH       0
`define RTX_B_REUSE       1
`define RTX_RST_RETRY     8'h03
`define RTX_RST_CHAN      7'h02
`endif

//--- common/rtx_pkg.sv
/*
 types of the packet transaction engine; no assumptions
*/
package rtx_pkg;
  typedef enum logic [2:0] {
    RTX_STBY1, RTX_STBY2, RTX_TX, RTX_WAIT_ACK,
    RTX_RETRY_WAIT, RTX_RX_SEARCH, RTX_ACK_TX
  } rtx_state_t;
endpackage

//--- tb/rtx_peer.sv
/*
 peer transceiver: ends each send with done, answers data packets with
 an ack per ack_mode (0 none, 1 empty, 2 payload), injects packets on
 pkt_go. assumes one-cycle pulses on pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module rtx_peer (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // from engine
  input  wire logic        air_tx_start,
  input  wire logic        air_tx_is_ack,
  input  wire logic        air_tx_no_ack,
  // to engine
  output logic             air_tx_done,
  output logic             air_addr_match,
  output logic             air_rx_valid,
  output logic             air_rx_crc_ok,
  output logic [2:0]       air_rx_pipe,
  output logic [1:0]       air_rx_pid,
  output logic [15:0]      air_rx_crc,
  output logic             air_rx_no_ack,
  output logic             air_rx_has_pay,
  output logic [31:0]      air_rx_data,
  // bench control
  input  wire logic [1:0]  ack_mode,
  input  wire logic        pkt_go,
  input  wire logic [1:0]  pkt_pid,
  input  wire logic        pkt_no_ack,
  input  wire logic [31:0] pkt_data
);
  logic [3:0] tx_cnt;
  logic [2:0] ack_cnt;
  logic       want_ack;
  logic       fire;
  assign fire = (ack_cnt == 3'h1) || pkt_go;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt <= 4'h0;
      ack_cnt <= 3'h0;
      want_ack <= 1'b0;
      air_tx_done <= 1'b0;
      air_addr_match <= 1'b0;
      air_rx_valid <= 1'b0;
      air_rx_data <= 32'h0;
    end else begin
      air_tx_done <= (tx_cnt == 4'h1);
      // acks only for data packets that ask for one
      if (air_tx_start) begin
        tx_cnt <= 4'h6;
        want_ack <= !air_tx_is_ack && !air_tx_no_ack && ack_mode != 2'h0;
      end else if (tx_cnt != 4'h0) begin
        tx_cnt <= tx_cnt - 4'h1;
      end
      if (tx_cnt == 4'h1 && want_ack) begin
        ack_cnt <= 3'h3;
      end else if (ack_cnt != 3'h0) begin
        ack_cnt <= ack_cnt - 3'h1;
      end
      air_addr_match <= (ack_cnt == 3'h2);
      air_rx_valid <= fire;
      // released data line toggles so stale values never look valid
      air_rx_data <= fire ? pkt_data : ~air_rx_data;
    end
  end
  always_ff @(posedge pclk) begin
    air_rx_crc_ok <= 1'b1;
    air_rx_pipe <= 3'h0;
    air_rx_pid <= pkt_pid;
    air_rx_crc <= pkt_data[15:0];
    air_rx_no_ack <= pkt_no_ack;
    air_rx_has_pay <= (ack_cnt == 3'h1) ? (ack_mode == 2'h2) : 1'b1;
  end
endmodule
`default_nettype wire

//--- tb/rtx_engine_tb.sv
/*
 self-checking bench of the transaction engine: apb master tasks,
 peer model on the air side, one task per scenario.
 assumes shortened delay parameters.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rtx_defines.svh"
module rtx_engine_tb;
  import rtx_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, air_tx_data, air_rx_data, rx_fifo_data;
  logic        chip_enable, air_tx_start, air_tx_no_ack, air_tx_is_ack;
  logic        air_tx_has_pay, air_tx_done, air_addr_match, air_rx_valid;
  logic        air_rx_crc_ok, air_rx_no_ack, air_rx_has_pay, rx_fifo_valid;
  logic [2:0]  air_rx_pipe;
  logic [1:0]  air_rx_pid, ack_mode, pkt_pid;
  logic [15:0] air_rx_crc;
  logic        pkt_go, pkt_no_ack, perr;
  logic [1:0]  tx_pid_o, p0;
  logic [2:0]  fifo_pipe;
  logic [31:0] pkt_data, rd, last_fifo;
  int miscompares, n_tests, n_start, n_fifo, cyc, t_done, gap, s0, f0;

  rtx_engine #(.ARD_STEP_CYC(20), .AW_CYC(10), .AW_LOW_CYC(20)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chip_enable(chip_enable),
    .air_tx_start(air_tx_start), .air_tx_data(air_tx_data),
    .air_tx_pid(tx_pid_o), .air_tx_no_ack(air_tx_no_ack),
    .air_tx_is_ack(air_tx_is_ack), .air_tx_has_pay(air_tx_has_pay),
    .air_tx_done(air_tx_done), .air_addr_match(air_addr_match),
    .air_rx_valid(air_rx_valid), .air_rx_crc_ok(air_rx_crc_ok),
    .air_rx_pipe(air_rx_pipe), .air_rx_pid(air_rx_pid),
    .air_rx_crc(air_rx_crc), .air_rx_no_ack(air_rx_no_ack),
    .air_rx_has_pay(air_rx_has_pay), .air_rx_data(air_rx_data),
    .rx_fifo_valid(rx_fifo_valid), .rx_fifo_data(rx_fifo_data),
    .rx_fifo_pipe(fifo_pipe));
  rtx_peer peer (
    .pclk(pclk), .presetn(presetn), .air_tx_start(air_tx_start),
    .air_tx_is_ack(air_tx_is_ack), .air_tx_no_ack(air_tx_no_ack),
    .air_tx_done(air_tx_done), .air_addr_match(air_addr_match),
    .air_rx_valid(air_rx_valid), .air_rx_crc_ok(air_rx_crc_ok),
    .air_rx_pipe(air_rx_pipe), .air_rx_pid(air_rx_pid),
    .air_rx_crc(air_rx_crc), .air_rx_no_ack(air_rx_no_ack),
    .air_rx_has_pay(air_rx_has_pay), .air_rx_data(air_rx_data),
    .ack_mode(ack_mode), .pkt_go(pkt_go), .pkt_pid(pkt_pid),
    .pkt_no_ack(pkt_no_ack), .pkt_data(pkt_data));

  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (air_tx_done === 1'b1) t_done = cyc;
    if (air_tx_start === 1'b1) begin
      n_start++;
      gap = cyc - t_done;
    end
    if (rx_fifo_valid === 1'b1) begin
      n_fifo++;
      last_fifo = rx_fifo_data;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send_tx(input logic [31:0] d);
    int j;
    s0 = n_start;
    apb(1'b1, `RTX_A_TXDATA, d);
    chip_enable <= 1'b1;
    for (j = 0; j < 500 && n_start == s0; j++) @(posedge pclk);
  endtask
  task automatic poll(input logic [31:0] m);
    int j;
    for (j = 0; j < 200; j++) begin
      apb(1'b0, `RTX_A_STATUS, 32'h0);
      if ((rd & m) != 0) break;
    end
  endtask
  task automatic rx_step(input logic [1:0] p, input logic na,
                         input logic [31:0] d, input int ef, es);
    s0 = n_start;
    f0 = n_fifo;
    @(posedge pclk);
    pkt_go <= 1'b1;
    pkt_pid <= p;
    pkt_no_ack <= na;
    pkt_data <= d;
    @(posedge pclk);
    pkt_go <= 1'b0;
    repeat (30) @(posedge pclk);
    chk(n_fifo - f0, ef);
    chk(n_start - s0, es);
  endtask

  task automatic t_reset;
    apb(1'b0, `RTX_A_RETRY, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, `RTX_A_OBSERVE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(perr), 32'h1);
    $display("reset test finished");
  endtask
  task automatic t_send;
    ack_mode <= 2'h1;
    apb(1'b1, `RTX_A_CTRL, 32'h2);
    // delay code 1 leaves room for any ack payload
    apb(1'b1, `RTX_A_RETRY, 32'h13);
    send_tx(32'h1234_5678);
    chk(air_tx_data, 32'h1234_5678);
    p0 = tx_pid_o;
    poll(32'h2);
    chk(rd & 32'h7, 32'h2);
    apb(1'b0, `RTX_A_STATUS, 32'h0);
    chk(32'(rd[10:8]), 32'(RTX_STBY2));
    chip_enable <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, `RTX_A_STATUS, 32'h0);
    chk(32'(rd[10:8]), 32'(RTX_STBY1));
    apb(1'b1, `RTX_A_STATUS, 32'h7);
    ack_mode <= 2'h2;
    send_tx(32'h0bad_cafe);
    chk(32'(2'(tx_pid_o - p0)), 32'h1);
    poll(32'h2);
    chk(rd & 32'h3, 32'h3);
    chip_enable <= 1'b0;
    apb(1'b1, `RTX_A_STATUS, 32'h7);
    $display("send test finished");
  endtask
  task automatic t_retry;
    ack_mode <= 2'h0;
    apb(1'b1, `RTX_A_RETRY, 32'h02);
    send_tx(32'h5a5a_0001);
    // chip enable drops once the send is under way, so the stop at the
    // limit is not followed by a fresh attempt at the kept payload
    chip_enable <= 1'b0;
    poll(32'h4);
    chk(n_start - s0, 3);
    chk(rd & 32'h7, 32'h4);
    chk(32'((gap >= 20) && (gap <= 24)), 32'h1);
    apb(1'b0, `RTX_A_OBSERVE, 32'h0);
    chk(rd & 32'hff, 32'h32);
    apb(1'b1, `RTX_A_CHAN, 32'h05);
    apb(1'b0, `RTX_A_OBSERVE, 32'h0);
    chk(rd & 32'hf0, 32'h0);
    chip_enable <= 1'b0;
    apb(1'b1, `RTX_A_STATUS, 32'h7);
    apb(1'b1, `RTX_A_CTRL, 32'h22);
    apb(1'b1, `RTX_A_CMD, 32'h1);
    ack_mode <= 2'h1;
    send_tx(32'h5a5a_0002);
    chk(32'(air_tx_no_ack), 32'h1);
    chk(air_tx_data, 32'h5a5a_0002);
    repeat (80) @(posedge pclk);
    chk(n_start - s0, 1);
    apb(1'b0, `RTX_A_OBSERVE, 32'h0);
    chk(rd & 32'hf, 32'h0);
    chip_enable <= 1'b0;
    // reuse: the kept payload goes out once per chip enable pulse
    apb(1'b1, `RTX_A_TXDATA, 32'h5a5a_0003);
    apb(1'b1, `RTX_A_CMD, 32'h2);
    s0 = n_start;
    repeat (2) begin
      chip_enable <= 1'b1;
      @(posedge pclk);
      chip_enable <= 1'b0;
      repeat (30) @(posedge pclk);
    end
    chk(n_start - s0, 2);
    chk(air_tx_data, 32'h5a5a_0003);
    apb(1'b1, `RTX_A_CMD, 32'h1);
    $display("retry test finished");
  endtask
  task automatic t_rx;
    apb(1'b1, `RTX_A_CTRL, 32'h3);
    chip_enable <= 1'b1;
    rx_step(2'h1, 1'b0, 32'h1111_aaaa, 1, 1);
    chk(last_fifo, 32'h1111_aaaa);
    chk(32'(air_tx_is_ack), 32'h1);
    chk(32'(fifo_pipe), 32'h0);
    rx_step(2'h1, 1'b0, 32'h1111_aaaa, 0, 1);
    rx_step(2'h1, 1'b0, 32'h2222_bbbb, 1, 1);
    rx_step(2'h2, 1'b1, 32'h3333_cccc, 1, 0);
    apb(1'b1, `RTX_A_REPLY, 32'h99);
    apb(1'b0, `RTX_A_STATUS, 32'h0);
    chk(32'(rd[6:5]), 32'h0);
    apb(1'b1, `RTX_A_CTRL, 32'hf);
    for (int k = 0; k < 4; k++) apb(1'b1, `RTX_A_REPLY, 32'h100 + k);
    apb(1'b0, `RTX_A_STATUS, 32'h0);
    chk(32'(rd[6:5]), 32'h3);
    apb(1'b1, `RTX_A_CMD, 32'h1);
    apb(1'b0, `RTX_A_STATUS, 32'h0);
    chk(32'(rd[6:5]), 32'h0);
    apb(1'b1, `RTX_A_REPLY, 32'h0000_0a01);
    apb(1'b1, `RTX_A_REPLY, 32'h0000_0a02);
    rx_step(2'h3, 1'b0, 32'h4444_dddd, 1, 1);
    chk({air_tx_has_pay, air_tx_data[30:0]}, 32'h8000_0a01);
    rx_step(2'h0, 1'b0, 32'h5555_eeee, 1, 1);
    chk(air_tx_data, 32'h0000_0a02);
    chip_enable <= 1'b0;
    $display("receive test finished");
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, chip_enable, pkt_go, pkt_no_ack} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pkt_data = 32'h0;
    pkt_pid = 2'h0;
    ack_mode = 2'h0;
    {miscompares, n_tests, n_start, n_fifo, cyc, t_done, gap} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_send();
    t_retry();
    t_rx();
    test_done();
  end
  initial begin
    // the scenarios need under a thousand cycles; allow far more
    #500000;
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
